// file: src/ext_port_pkg.sv
// Constants shared by the external control handshake port and its helpers.
// Assumes a single 100 MHz clock domain and a 32-bit APB register bus.
package ext_port_pkg;

	// Clock rate and the panel-select hold time.
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned LOAD_HOLD_MS = 10;
	localparam int unsigned LOAD_HOLD_CYC = LOAD_HOLD_MS * (CLK_HZ / 1000);

	// Register byte offsets.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
	localparam logic [7:0] RESULT_OFS = 8'h10;
	localparam logic [7:0] SPARE_OUT_OFS = 8'h14;
	localparam logic [7:0] SPARE_IN_OFS = 8'h18;
	localparam logic [7:0] CMD_OFS = 8'h1C;

	// Control register fields.
	localparam int CTRL_EXT_BIT = 0;
	localparam int CTRL_BIN_BIT = 1;
	localparam int CTRL_CNT_LSB = 8;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_RESET = 8'h01;

	// Status register fields.
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_LOAD_BIT = 1;
	localparam int ST_LOCK_BIT = 2;
	localparam int ST_DONE_BIT = 3;
	localparam int ST_PANEL_LSB = 4;

	// Event bits, shared by the interrupt status and mask registers.
	localparam int EV_W = 5;
	localparam int EV_START = 0;
	localparam int EV_DONE = 1;
	localparam int EV_PRINT = 2;
	localparam int EV_LOAD = 3;
	localparam int EV_LOCK = 4;

	// Result register fields.
	localparam int RES_OVER_BIT = 0;
	localparam int RES_PASS_BIT = 1;
	localparam int RES_UNDER_BIT = 2;
	localparam int RES_FAULT_BIT = 3;
	localparam int RES_OOB_BIT = 4;
	localparam int RES_CAT_LSB = 5;

	// Command register fields.
	localparam int CMD_LOADED_BIT = 0;

	// Pin group widths.
	localparam int PANEL_W = 5;
	localparam int CAT_W = 10;
	localparam int SPARE_OUT_W = 11;
	localparam int SPARE_IN_W = 2;

endpackage : ext_port_pkg

// file: src/pin_sync_edge.sv
// Two-stage synchroniser with rising-edge detection for a group of pins.
// Assumes the pins are asynchronous to pclk; the first stage feeds only the second.
`timescale 1ns/1ns
module pin_sync_edge #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] level,
	output logic [W-1:0] rise
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] last_reg;

	// Synchronise, then keep one more stage to find edges on clean data.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			level <= '0;
			last_reg <= '0;
		end else begin
			meta_reg <= din;
			level <= meta_reg;
			last_reg <= level;
		end
	end

	assign rise = level & ~last_reg;

endmodule : pin_sync_edge

// file: src/hold_timer.sv
// Stability timer: pulses once when a bus value has changed and then held
// unchanged for CYCLES clocks. Input must already be synchronous to pclk.
`timescale 1ns/1ns
module hold_timer #(
	parameter int W = 5,
	parameter int unsigned CYCLES = 1000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] value,
	output logic fire,
	output logic [W-1:0] held
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_reg;
	logic armed_reg;

	// Any change restarts the window; only a full quiet window fires.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held <= '0;
			cnt_reg <= '0;
			armed_reg <= 1'b0;
			fire <= 1'b0;
		end else begin
			fire <= 1'b0;
			if (value != held) begin
				held <= value;
				cnt_reg <= '0;
				armed_reg <= 1'b1;
			end else if (armed_reg) begin
				if (cnt_reg == LAST) begin
					fire <= 1'b1;
					armed_reg <= 1'b0;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
		end
	end

endmodule : hold_timer

// file: src/ext_control_port.sv
// External control handshake port: trigger, completion, judgment, bin,
// panel select, key lock, print and spare lines, with an APB register file.
// Assumes firmware measures on request and posts each result over APB.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module ext_control_port #(
	parameter int unsigned LOAD_HOLD_CYCLES = ext_port_pkg::LOAD_HOLD_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic measure_start_input,
	input wire logic hardcopy_request,
	input wire logic front_panel_disable,
	input wire logic [ext_port_pkg::PANEL_W-1:0] panel_select_lines,
	output logic measure_done,
	output logic over_limit,
	output logic pass_judgment,
	output logic under_limit,
	output logic measurement_fault,
	output logic [ext_port_pkg::CAT_W-1:0] category_outputs,
	output logic out_of_range_bin,
	output logic key_lock_active,
	output logic print_pulse,
	output logic measure_begin
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation.

	logic [ext_port_pkg::SPARE_IN_W-1:0] edge_lvl;
	logic [ext_port_pkg::SPARE_IN_W-1:0] edge_rise;
	logic lock_lvl;
	logic [ext_port_pkg::PANEL_W-1:0] panel_lvl;
	logic load_fire;
	logic [ext_port_pkg::PANEL_W-1:0] panel_held;

	// edge and spare
	// Trigger and print pins double as the two spare sense lines.
	pin_sync_edge #(.W(ext_port_pkg::SPARE_IN_W)) u_edge_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({hardcopy_request, measure_start_input}),
		.level(edge_lvl),
		.rise(edge_rise)
	);

	// Key lock and panel lines are levels; edges are not used.
	pin_sync_edge #(.W(ext_port_pkg::PANEL_W + 1)) u_level_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({front_panel_disable, panel_select_lines}),
		.level({lock_lvl, panel_lvl}),
		.rise()
	);

	// hold window
	// A panel number is accepted only after it held still for the window.
	hold_timer #(.W(ext_port_pkg::PANEL_W), .CYCLES(LOAD_HOLD_CYCLES)) u_hold (
		.pclk(pclk),
		.presetn(presetn),
		.value(panel_lvl),
		.fire(load_fire),
		.held(panel_held)
	);

	////////////////////////////////////////////////////////////////////////
	// APB decode.

	// Compare a bus address with a register offset.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	logic wr_en;
	logic known;
	assign wr_en = psel & penable & pwrite & pready;
	assign known = hit(paddr, ext_port_pkg::CTRL_OFS) | hit(paddr, ext_port_pkg::STATUS_OFS) |
		hit(paddr, ext_port_pkg::IRQ_STAT_OFS) | hit(paddr, ext_port_pkg::IRQ_MASK_OFS) |
		hit(paddr, ext_port_pkg::RESULT_OFS) | hit(paddr, ext_port_pkg::SPARE_OUT_OFS) |
		hit(paddr, ext_port_pkg::SPARE_IN_OFS) | hit(paddr, ext_port_pkg::CMD_OFS);

	////////////////////////////////////////////////////////////////////////
	// Registers and state.

	logic measure_start_input_ext_reg;
	logic bin_mode_reg;
	logic [ext_port_pkg::CNT_W-1:0] meas_count_reg;
	logic busy_reg;
	logic [ext_port_pkg::CNT_W-1:0] remaining_reg;
	logic load_busy_reg;
	logic [ext_port_pkg::PANEL_W-1:0] panel_reg;
	logic [ext_port_pkg::EV_W-1:0] irq_stat_reg;
	logic [ext_port_pkg::EV_W-1:0] irq_mask_reg;
	logic [ext_port_pkg::SPARE_OUT_W-1:0] spare_out_reg;
	logic [31:0] status_word;
	logic start_ev;
	logic done_ev;
	logic result_wr;
	logic lock_chg;
	logic [ext_port_pkg::EV_W-1:0] events;

	// external source only
	// A start edge counts only when externally triggered, idle and not loading.
	assign start_ev = edge_rise[0] & measure_start_input_ext_reg & ~busy_reg & ~load_busy_reg;
	assign result_wr = wr_en & hit(paddr, ext_port_pkg::RESULT_OFS) & busy_reg;
	assign done_ev = result_wr & (remaining_reg <= 8'h01);
	assign lock_chg = lock_lvl ^ key_lock_active;
	assign events = {lock_chg, load_fire, edge_rise[1], done_ev, start_ev};

	// Software settings: trigger source, bin mode, count of runs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			measure_start_input_ext_reg <= 1'b0;
			bin_mode_reg <= 1'b0;
			meas_count_reg <= ext_port_pkg::CNT_RESET;
		end else if (wr_en && hit(paddr, ext_port_pkg::CTRL_OFS)) begin
			measure_start_input_ext_reg <= pwdata[ext_port_pkg::CTRL_EXT_BIT];
			bin_mode_reg <= pwdata[ext_port_pkg::CTRL_BIN_BIT];
			meas_count_reg <= pwdata[ext_port_pkg::CTRL_CNT_LSB +: ext_port_pkg::CNT_W];
		end
	end

	// counted runs
	// Each posted result uses one run; the last one ends the sequence.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			remaining_reg <= '0;
		end else if (start_ev) begin
			busy_reg <= 1'b1;
			remaining_reg <= (meas_count_reg == '0) ? 8'h01 : meas_count_reg;
		end else if (result_wr) begin
			busy_reg <= ~done_ev;
			remaining_reg <= remaining_reg - 8'h01;
		end
	end

	// done with judgment
	// Judgment lines change only together with the rise of done.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			measure_done <= 1'b0;
			over_limit <= 1'b0;
			pass_judgment <= 1'b0;
			under_limit <= 1'b0;
			measurement_fault <= 1'b0;
		end else if (start_ev) begin
			measure_done <= 1'b0;
		end else if (done_ev) begin
			measure_done <= 1'b1;
			over_limit <= pwdata[ext_port_pkg::RES_OVER_BIT];
			pass_judgment <= pwdata[ext_port_pkg::RES_PASS_BIT];
			under_limit <= pwdata[ext_port_pkg::RES_UNDER_BIT];
			measurement_fault <= pwdata[ext_port_pkg::RES_FAULT_BIT];
		end
	end

	// spare outputs
	// Bin pins are shared with spare drive lines; bin mode takes them over.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			category_outputs <= '0;
			out_of_range_bin <= 1'b0;
		end else if (!bin_mode_reg) begin
			out_of_range_bin <= spare_out_reg[0];
			category_outputs <= spare_out_reg[ext_port_pkg::SPARE_OUT_W-1:1];
		end else if (done_ev) begin
			out_of_range_bin <= pwdata[ext_port_pkg::RES_OOB_BIT];
			category_outputs <= pwdata[ext_port_pkg::RES_CAT_LSB +: ext_port_pkg::CAT_W];
		end
	end

	// Spare drive value written by the remote command path.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spare_out_reg <= '0;
		end else if (wr_en && hit(paddr, ext_port_pkg::SPARE_OUT_OFS)) begin
			spare_out_reg <= pwdata[ext_port_pkg::SPARE_OUT_W-1:0];
		end
	end

	// load completes
	// Load stays busy until firmware reports the panel applied.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_busy_reg <= 1'b0;
			panel_reg <= '0;
		end else if (load_fire) begin
			load_busy_reg <= 1'b1;
			panel_reg <= panel_held;
		end else if (wr_en && hit(paddr, ext_port_pkg::CMD_OFS) &&
			pwdata[ext_port_pkg::CMD_LOADED_BIT]) begin
			load_busy_reg <= 1'b0;
		end
	end

	// level key lock
	// Lock follows the level; print and start are single-cycle strobes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_lock_active <= 1'b0;
			print_pulse <= 1'b0;
			measure_begin <= 1'b0;
		end else begin
			key_lock_active <= lock_lvl;
			print_pulse <= edge_rise[1];
			measure_begin <= start_ev;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts.

	// Sticky events; a new event wins over a same-cycle write-one clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= '0;
		end else if (wr_en && hit(paddr, ext_port_pkg::IRQ_STAT_OFS)) begin
			irq_stat_reg <= (irq_stat_reg & ~pwdata[ext_port_pkg::EV_W-1:0]) | events;
		end else begin
			irq_stat_reg <= irq_stat_reg | events;
		end
	end

	// Mask register: a one enables that event onto the interrupt line.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= '0;
		end else if (wr_en && hit(paddr, ext_port_pkg::IRQ_MASK_OFS)) begin
			irq_mask_reg <= pwdata[ext_port_pkg::EV_W-1:0];
		end
	end

	// Registered level interrupt; lags the status bits by one clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB read path and answer.

	// Status word shows live handshake state and the accepted panel.
	always_comb begin
		status_word = '0;
		status_word[ext_port_pkg::ST_BUSY_BIT] = busy_reg;
		status_word[ext_port_pkg::ST_LOAD_BIT] = load_busy_reg;
		status_word[ext_port_pkg::ST_LOCK_BIT] = key_lock_active;
		status_word[ext_port_pkg::ST_DONE_BIT] = measure_done;
		status_word[ext_port_pkg::ST_PANEL_LSB +: ext_port_pkg::PANEL_W] = panel_reg;
	end

	// One wait state: pready rises in the second access cycle, so every
	// transfer takes exactly three clocks including setup.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= ~known;
			prdata <= '0;
			if (!pwrite) begin
				if (hit(paddr, ext_port_pkg::CTRL_OFS)) begin
					prdata[ext_port_pkg::CTRL_EXT_BIT] <= measure_start_input_ext_reg;
					prdata[ext_port_pkg::CTRL_BIN_BIT] <= bin_mode_reg;
					prdata[ext_port_pkg::CTRL_CNT_LSB +: ext_port_pkg::CNT_W] <= meas_count_reg;
				end else if (hit(paddr, ext_port_pkg::STATUS_OFS)) begin
					prdata <= status_word;
				end else if (hit(paddr, ext_port_pkg::IRQ_STAT_OFS)) begin
					prdata[ext_port_pkg::EV_W-1:0] <= irq_stat_reg;
				end else if (hit(paddr, ext_port_pkg::IRQ_MASK_OFS)) begin
					prdata[ext_port_pkg::EV_W-1:0] <= irq_mask_reg;
				end else if (hit(paddr, ext_port_pkg::SPARE_OUT_OFS)) begin
					prdata[ext_port_pkg::SPARE_OUT_W-1:0] <= spare_out_reg;
				end else if (hit(paddr, ext_port_pkg::SPARE_IN_OFS)) begin
					prdata[ext_port_pkg::SPARE_IN_W-1:0] <= edge_lvl;
				end
			end
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule : ext_control_port

// file: bench/ext_control_port_chk.sv
// Checker for the external control port, watching top-level ports only.
// Assumes the single pclk domain with presetn as its asynchronous reset.
`timescale 1ns/1ns
module ext_control_port_chk #(
	parameter int unsigned LOAD_HOLD_CYCLES = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic hardcopy_request,
	input wire logic front_panel_disable,
	input wire logic measure_done,
	input wire logic over_limit,
	input wire logic pass_judgment,
	input wire logic under_limit,
	input wire logic measurement_fault,
	input wire logic key_lock_active,
	input wire logic print_pulse,
	input wire logic measure_begin
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// Judgment lines may only move at a completion, never mid-run.
	AST_DONE_FALL: assert property (measure_begin |-> !measure_done)
		else $error("done high at start");
	AST_BEGIN_ONE: assert property (measure_begin |=> !measure_begin)
		else $error("begin too long");
	AST_DONE_STAYS: assert property ($fell(measure_done) |-> measure_begin)
		else $error("done fell alone");
	AST_JUDGE_HOLD: assert property (!measure_done ##1 !measure_done |->
		$stable({over_limit, pass_judgment, under_limit, measurement_fault}))
		else $error("judgment moved early");
	AST_LOCK_FOLLOW: assert property ($changed(front_panel_disable) |->
		##[1:4] (key_lock_active == front_panel_disable))
		else $error("lock lag");
	AST_PRINT_EDGE: assert property ($rose(hardcopy_request) |-> ##[1:4] print_pulse)
		else $error("print missing");
	AST_PRINT_ONE: assert property (print_pulse |=> !print_pulse)
		else $error("print too long");
	AST_APB_WAIT: assert property (psel && !penable |-> ##2 pready)
		else $error("ready late");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("ready too long");
endmodule : ext_control_port_chk

bind ext_control_port ext_control_port_chk #(.LOAD_HOLD_CYCLES(LOAD_HOLD_CYCLES)) u_chk (
	.pclk, .presetn, .psel, .penable, .pready, .pslverr, .hardcopy_request,
	.front_panel_disable, .measure_done, .over_limit, .pass_judgment, .under_limit,
	.measurement_fault, .key_lock_active, .print_pulse, .measure_begin);

// file: bench/plc_model.sv
// Controller model driving the port's input pins.
// Assumes pins change just after rising edges of pclk.
`timescale 1ns/1ns
module plc_model #(
	parameter int HOLD = 20
) (
	input wire logic pclk,
	output logic measure_start_input,
	output logic hardcopy_request,
	output logic front_panel_disable,
	output logic [ext_port_pkg::PANEL_W-1:0] panel_select_lines
);
	// uniform panel lines
	// Idle levels; all panel lines open so no load is asked for.
	initial begin
		measure_start_input = 1'b0;
		hardcopy_request = 1'b0;
		front_panel_disable = 1'b0;
		panel_select_lines = '0;
	end
	////////////////////////////////////////////////////////////////
	// edge pins
	// Raise trigger or print for w cycles; a large w is a slow controller.
	task automatic pulse(input logic prn, input int w);
		@(posedge pclk);
		if (prn) hardcopy_request <= 1'b1;
		else measure_start_input <= 1'b1;
		repeat (w) @(posedge pclk);
		hardcopy_request <= 1'b0;
		measure_start_input <= 1'b0;
	endtask : pulse
	// hold panel number
	// The number stays put; moving it would start another load.
	task automatic load(input logic [ext_port_pkg::PANEL_W-1:0] n);
		@(posedge pclk);
		panel_select_lines <= n;
		repeat (HOLD + 10) @(posedge pclk);
	endtask : load
	task automatic lock(input logic v);
		@(posedge pclk);
		front_panel_disable <= v;
	endtask : lock
endmodule : plc_model

// file: bench/ext_control_handshake_port_bench.sv
// Self-checking bench for the external control port.
// Assumes the APB slave answers with pready; pins come from plc_model.
`timescale 1ns/1ns
module ext_control_handshake_port_bench;
	localparam int HOLD = 20;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic measure_start_input, hardcopy_request, front_panel_disable, measure_done;
	logic over_limit, pass_judgment, under_limit, measurement_fault, out_of_range_bin;
	logic key_lock_active, print_pulse, measure_begin;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [ext_port_pkg::PANEL_W-1:0] panel_select_lines;
	logic [ext_port_pkg::CAT_W-1:0] category_outputs;
	int n_fail, checks, n_beg, n_prt, cyc;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] spare;
		logic [31:0] res;
		logic [14:0] exp;
	} row_s;
	// The first two rows show spare bits on the bin lines; the last two set bin mode and show the result.
	row_s rows [4] = '{'{32'h0000_0101, 32'h0000_0555, 32'h0000_7FE1, 15'h5551},
		'{32'h0000_0101, 32'h0000_00F0, 32'h0000_000A, 15'h0F0A},
		'{32'h0000_0103, 32'h0000_07FF, 32'h0000_2A35, 15'h2A35},
		'{32'h0000_0103, 32'h0000_0123, 32'h0000_0000, 15'h0000}};

	ext_control_port #(.LOAD_HOLD_CYCLES(HOLD)) u_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .measure_start_input,
		.hardcopy_request, .front_panel_disable, .panel_select_lines, .measure_done,
		.over_limit, .pass_judgment, .under_limit, .measurement_fault, .category_outputs,
		.out_of_range_bin, .key_lock_active, .print_pulse, .measure_begin);
	plc_model #(.HOLD(HOLD)) u_plc (.pclk, .measure_start_input, .hardcopy_request,
		.front_panel_disable, .panel_select_lines);

	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		if (n_fail == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	// One APB transfer; held until pready is seen at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e, m);
	endtask : rchk
	// Trigger pin pulse, then count accepted starts.
	task automatic start(input int e);
		int b;
		b = n_beg;
		u_plc.pulse(1'b0, 6);
		repeat (2) @(posedge pclk);
		#1;
		chk(n_beg - b, e, "start count");
	endtask : start
	task automatic wait_done;
		for (int i = 0; i < 50 && measure_done !== 1'b1; i++) @(posedge pclk);
		chk(measure_done, 1'b1, "done missing");
	endtask : wait_done

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Pulse counters and the hang limit; a run needs well under 4000 cycles.
	always @(posedge pclk) begin
		cyc++;
		if (measure_begin === 1'b1) n_beg++;
		if (print_pulse === 1'b1) n_prt++;
		if (cyc == 4000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rchk(ext_port_pkg::CTRL_OFS, 32'h0000_0100, "ctrl reset");
		rchk(ext_port_pkg::STATUS_OFS, 32'h0000_0000, "status reset");
		rchk(8'h20, 32'h0000_0000, "unmapped");
		chk(err, 1'b1, "unmapped err");
		foreach (rows[i]) begin
			apb(1'b1, ext_port_pkg::CTRL_OFS, rows[i].ctrl);
			apb(1'b1, ext_port_pkg::SPARE_OUT_OFS, rows[i].spare);
			start(1);
			apb(1'b1, ext_port_pkg::RESULT_OFS, rows[i].res);
			wait_done();
			chk({category_outputs, out_of_range_bin, measurement_fault, under_limit,
				pass_judgment, over_limit}, rows[i].exp, "judgment");
		end
		rchk(ext_port_pkg::SPARE_OUT_OFS, 32'h0000_0123, "spare out");
		// Two runs per start; an edge while busy is dropped.
		apb(1'b1, ext_port_pkg::CTRL_OFS, 32'h0000_0201);
		start(1);
		start(0);
		apb(1'b1, ext_port_pkg::RESULT_OFS, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		chk(measure_done, 1'b0, "done early");
		apb(1'b1, ext_port_pkg::RESULT_OFS, 32'h0000_0002);
		wait_done();
		chk(pass_judgment, 1'b1, "pass");
		apb(1'b1, ext_port_pkg::CTRL_OFS, 32'h0000_0100);
		start(0);
		apb(1'b1, ext_port_pkg::CTRL_OFS, 32'h0000_0101);
		u_plc.load(5'h13);
		rchk(ext_port_pkg::STATUS_OFS, 32'h0000_013A, "panel");
		start(0);
		apb(1'b1, ext_port_pkg::CMD_OFS, 32'h0000_0001);
		start(1);
		apb(1'b1, ext_port_pkg::RESULT_OFS, 32'h0000_0001);
		wait_done();
		rchk(ext_port_pkg::IRQ_STAT_OFS, 32'h0000_000B, "start done load events");
		apb(1'b1, ext_port_pkg::IRQ_STAT_OFS, 32'h0000_001F);
		fork
			u_plc.pulse(1'b1, 20);
			begin
				repeat (8) @(posedge pclk);
				rchk(ext_port_pkg::SPARE_IN_OFS, 32'h0000_0002, "spare in");
			end
		join
		repeat (2) @(posedge pclk);
		#1;
		chk(n_prt, 1, "print");
		chk(irq, 1'b0, "masked");
		rchk(ext_port_pkg::IRQ_STAT_OFS, 32'h0000_0004, "print event");
		apb(1'b1, ext_port_pkg::IRQ_MASK_OFS, 32'h0000_0004);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1, "irq");
		apb(1'b1, ext_port_pkg::IRQ_STAT_OFS, 32'h0000_0004);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0, "irq clear");
		u_plc.lock(1'b1);
		repeat (6) @(posedge pclk);
		rchk(ext_port_pkg::STATUS_OFS, 32'h0000_013C, "lock");
		rchk(ext_port_pkg::IRQ_STAT_OFS, 32'h0000_0010, "lock event");
		u_plc.lock(1'b0);
		repeat (6) @(posedge pclk);
		report_and_stop();
	end
endmodule : ext_control_handshake_port_bench
